// ### logic/timer_capture_compare_ctrl.sv
/*
  two-channel 16-bit timer: counter, legacy prescaler, capture/compare
  channels, compare pin actions, flags with fast clear, interrupt request.
  assumes channel pins synchronous to core_clk and an AHB-Lite master
  doing single whole-word transfers.
*/
// Function
// R1 - compare action: none, toggle, low, high
// R2 - mode or level set makes pin output
// R3 - compare drives pin only when connected
// R4 - edge select: off, rise, fall, both
// R5 - unimplemented bits ignore writes, read zero
// R6 - channel enables gate matching channel flags
// R7 - overflow enable bit 7 gates overflow flag
// R8 - prescale divides bus clock by 2^select
// R9 - new prescale waits for all-zero stages
// R10 - capture or compare event sets channel flag
// R11 - write one clears flag, zero keeps
// R12 - software clears channel flags while running
// R13 - fast clear: capture read, compare write
// R14 - fast clear: counter access clears overflow
// R15 - counter wrap sets overflow flag
// R16 - software clears overflow while running
// R17 - run enable stops or runs counter
// R18 - counter is 16-bit prescaled up counter
// R19 - active edge copies counter into channel
// R20 - disconnected pin still sets compare flag
// R21 - compare hit when counter equals channel
`timescale 1ns/100ps
`default_nettype none
module timer_capture_compare_ctrl #(
  parameter int NCH = 2
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // channel pins
  input  wire logic [NCH-1:0]  chanPinIn,
  output logic      [NCH-1:0]  chanPinOut,
  output logic      [NCH-1:0]  chanPinOe,
  // interrupt request
  output logic                 timerIrq
);
  // address phase capture
  logic                    wrPend_q, rdPend_q;
  logic [tcc_pkg::IDX_W-1:0] idx_q;
  logic                    addrOk;
  logic [tcc_pkg::IDX_W-1:0] idxNow;

  assign addrOk = hsel && hready && (htrans == tcc_pkg::HTRANS_NONSEQ ||
                                     htrans == tcc_pkg::HTRANS_SEQ);
  assign idxNow = haddr[tcc_pkg::IDX_LSB +: tcc_pkg::IDX_W];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      idx_q    <= '0;
    end else begin
      wrPend_q <= addrOk && hwrite;
      rdPend_q <= addrOk && !hwrite;
      if (addrOk) idx_q <= idxNow;
    end
  end

  // registers
  logic [7:0]       sysCtrl1_q, outHi_q, outLo_q, edgeHi_q, edgeLo_q, sysCtrl2_q;
  logic [NCH-1:0]   irqEn_q, chFlag_q, pinDisc_q;
  logic             ovfFlag_q;
  logic [15:0]      counter_q;
  logic [15:0]      chReg_q [NCH];
  logic [tcc_pkg::PRESC_W-1:0] prescAct_q;
  logic [tcc_pkg::DIV_W-1:0]   div_q;
  logic [NCH-1:0]   pinPrev_q;
  logic [NCH-1:0]   pinOut_q;
  logic             runEn, fastClr, tick;

  assign runEn   = sysCtrl1_q[tcc_pkg::RUN_EN_BIT];
  assign fastClr = sysCtrl1_q[tcc_pkg::FAST_CLR_BIT];

  // plain control registers; bits without a function are never stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sysCtrl1_q <= tcc_pkg::BYTE_RESET;
      outHi_q    <= tcc_pkg::BYTE_RESET;
      outLo_q    <= tcc_pkg::BYTE_RESET;
      edgeHi_q   <= tcc_pkg::BYTE_RESET;
      edgeLo_q   <= tcc_pkg::BYTE_RESET;
      sysCtrl2_q <= tcc_pkg::BYTE_RESET;
      irqEn_q    <= '0;
      pinDisc_q  <= '0;
    end else if (wrPend_q) begin
      unique case (idx_q)
        tcc_pkg::IDX_SYS_CTRL1: sysCtrl1_q <= hwdata[7:0] & 8'h90;
        tcc_pkg::IDX_OUT_HI:    outHi_q    <= hwdata[7:0] & 8'h00; // R5
        tcc_pkg::IDX_OUT_LO:    outLo_q    <= hwdata[7:0] & 8'h0f;
        tcc_pkg::IDX_EDGE_HI:   edgeHi_q   <= hwdata[7:0] & 8'h00; // R5
        tcc_pkg::IDX_EDGE_LO:   edgeLo_q   <= hwdata[7:0] & 8'h0f;
        tcc_pkg::IDX_IRQ_EN:    irqEn_q    <= hwdata[NCH-1:0];
        tcc_pkg::IDX_SYS_CTRL2: sysCtrl2_q <= hwdata[7:0] & 8'h87;
        tcc_pkg::IDX_PIN_DISC:  pinDisc_q  <= hwdata[NCH-1:0];
        default: ;
      endcase
    end
  end

  // prescaler: new select only loads when every stage is zero,
  // so a select written mid-period never cuts a timer period short
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q      <= '0;
      prescAct_q <= '0;
    end else if (runEn) begin // R17
      if (div_q == '0) prescAct_q <= sysCtrl2_q[tcc_pkg::PRESC_LSB +: tcc_pkg::PRESC_W]; // R9
      if (tick) div_q <= '0;
      else div_q <= div_q + 1'b1;
    end
  end
  // divide by 2^select: tick when the low select bits of the divider are all ones
  assign tick = runEn &&
    ((div_q & tcc_pkg::DIV_W'((1 << prescAct_q) - 1)) ==
     tcc_pkg::DIV_W'((1 << prescAct_q) - 1)); // R8

  // main counter: software writes are dropped so nothing upsets the count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) counter_q <= tcc_pkg::CNT_RESET;
    else if (tick) counter_q <= counter_q + 1'b1; // R18
  end

  // per-channel capture/compare
  logic [NCH-1:0] hit, capEv, cmpEv, modeOut, rdClr, wrClr;
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    logic [1:0] act, edg;
    logic       rise, fall;
    assign act = {outLo_q[2*g+1], outLo_q[2*g]};
    assign edg = {edgeLo_q[2*g+1], edgeLo_q[2*g]};
    assign modeOut[g] = act != tcc_pkg::ACT_NONE; // R2
    assign rise = chanPinIn[g] && !pinPrev_q[g];
    assign fall = !chanPinIn[g] && pinPrev_q[g];
    assign capEv[g] = !modeOut[g] && ((edg == tcc_pkg::EDGE_RISE && rise) ||
                      (edg == tcc_pkg::EDGE_FALL && fall) ||
                      (edg == tcc_pkg::EDGE_ANY && (rise || fall))); // R4
    assign hit[g]   = modeOut[g] && tick && (counter_q == chReg_q[g]); // R21
    assign cmpEv[g] = hit[g];
    // fast clear acts in the data phase, once the access is committed
    assign rdClr[g] = fastClr && rdPend_q && !modeOut[g] &&
                      idx_q == tcc_pkg::IDX_CH_REG0 + tcc_pkg::IDX_W'(g); // R13
    assign wrClr[g] = fastClr && wrPend_q && modeOut[g] &&
                      idx_q == tcc_pkg::IDX_CH_REG0 + tcc_pkg::IDX_W'(g); // R13

    // capture copies the counter; compare value written by software
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) chReg_q[g] <= tcc_pkg::CNT_RESET;
      else if (capEv[g]) chReg_q[g] <= counter_q; // R19
      else if (wrClr[g] || (wrPend_q && modeOut[g] &&
               idx_q == tcc_pkg::IDX_CH_REG0 + tcc_pkg::IDX_W'(g)))
        chReg_q[g] <= hwdata[15:0];
    end

    // pin action on compare, pin line held even while disconnected
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) pinOut_q[g] <= 1'b0;
      else if (hit[g]) begin
        unique case (act) // R1
          tcc_pkg::ACT_TOGGLE: pinOut_q[g] <= !pinOut_q[g];
          tcc_pkg::ACT_LOW:    pinOut_q[g] <= 1'b0;
          tcc_pkg::ACT_HIGH:   pinOut_q[g] <= 1'b1;
          default:             pinOut_q[g] <= pinOut_q[g];
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pinPrev_q <= '0;
    else pinPrev_q <= chanPinIn;
  end

  // pins: driven only when in compare mode and connected
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chanPinOut <= '0;
      chanPinOe  <= '0;
    end else begin
      chanPinOut <= pinOut_q & ~pinDisc_q; // R3
      chanPinOe  <= modeOut & ~pinDisc_q;  // R2 R3
    end
  end

  // flags: a set in the same cycle as a clear wins
  logic [NCH-1:0] chW1c;
  logic           ovfClr, cntAccess;
  assign chW1c = (wrPend_q && idx_q == tcc_pkg::IDX_CH_FLAGS) ? hwdata[NCH-1:0] : '0; // R11
  assign cntAccess = (wrPend_q || rdPend_q) && idx_q == tcc_pkg::IDX_COUNTER;
  assign ovfClr = (wrPend_q && idx_q == tcc_pkg::IDX_OVF_FLAGS &&
                   hwdata[tcc_pkg::OVF_FLAG_BIT]) || (fastClr && cntAccess); // R11 R14
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chFlag_q  <= '0;
      ovfFlag_q <= 1'b0;
    end else begin
      chFlag_q  <= (chFlag_q & ~(chW1c | rdClr | wrClr)) | capEv | cmpEv; // R10 R20
      ovfFlag_q <= (ovfFlag_q && !ovfClr) ||
                   (tick && counter_q == tcc_pkg::CNT_MAX); // R15
    end
  end

  // interrupt request from enabled flags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) timerIrq <= 1'b0;
    else timerIrq <= |(chFlag_q & irqEn_q) || // R6
                     (ovfFlag_q && sysCtrl2_q[tcc_pkg::OVF_IRQ_EN_BIT]); // R7
  end

  // read data, registered in the address phase so it stands in the data phase
  logic [31:0] rdMux;
  always_comb begin
    rdMux = tcc_pkg::WORD_ZERO;
    unique case (idxNow)
      tcc_pkg::IDX_COUNTER:   rdMux = {16'h0000, counter_q};
      tcc_pkg::IDX_SYS_CTRL1: rdMux = {24'h000000, sysCtrl1_q};
      tcc_pkg::IDX_OUT_HI:    rdMux = {24'h000000, outHi_q};
      tcc_pkg::IDX_OUT_LO:    rdMux = {24'h000000, outLo_q};
      tcc_pkg::IDX_EDGE_HI:   rdMux = {24'h000000, edgeHi_q};
      tcc_pkg::IDX_EDGE_LO:   rdMux = {24'h000000, edgeLo_q};
      tcc_pkg::IDX_IRQ_EN:    rdMux[NCH-1:0] = irqEn_q;
      tcc_pkg::IDX_SYS_CTRL2: rdMux = {24'h000000, sysCtrl2_q};
      tcc_pkg::IDX_CH_FLAGS:  rdMux[NCH-1:0] = chFlag_q; // R5
      tcc_pkg::IDX_OVF_FLAGS: rdMux[tcc_pkg::OVF_FLAG_BIT] = ovfFlag_q;
      tcc_pkg::IDX_CH_REG0:   rdMux = {16'h0000, chReg_q[0]};
      tcc_pkg::IDX_CH_REG1:   rdMux = {16'h0000, chReg_q[1]};
      tcc_pkg::IDX_PIN_DISC:  rdMux[NCH-1:0] = pinDisc_q;
      tcc_pkg::IDX_IRQ_STATUS: rdMux = {30'h0, timerIrq, runEn};
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata    <= tcc_pkg::WORD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1; // zero wait states
      hresp     <= 1'b0;
      if (addrOk && !hwrite) hrdata <= rdMux;
    end
  end

  // assertions
  a_ovf_wrap: assert property (@(posedge core_clk) disable iff (!arst_n) // R15
    tick && counter_q == tcc_pkg::CNT_MAX |=> ovfFlag_q && counter_q == tcc_pkg::CNT_RESET)
    else $error("overflow flag not set on wrap");
  a_cnt_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // R17
    !runEn |=> $stable(counter_q))
    else $error("counter moved while stopped");
  a_cnt_step: assert property (@(posedge core_clk) disable iff (!arst_n) // R18
    tick |=> counter_q == $past(counter_q) + 16'h0001)
    else $error("counter did not step");
  a_div_one: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
    runEn && prescAct_q == 3'h0 |-> tick)
    else $error("divide by one missed tick");
  a_presc_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
    div_q != '0 |=> $stable(prescAct_q))
    else $error("prescale changed mid period");

  // flags and interrupt request
  a_ch_set: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
    capEv[0] || cmpEv[0] |=> chFlag_q[0])
    else $error("channel flag not set");
  a_w1c_clr: assert property (@(posedge core_clk) disable iff (!arst_n) // R11
    chW1c[0] && !capEv[0] && !cmpEv[0] |=> !chFlag_q[0])
    else $error("write one did not clear");
  a_w0_keep: assert property (@(posedge core_clk) disable iff (!arst_n) // R11
    wrPend_q && idx_q == tcc_pkg::IDX_CH_FLAGS && !hwdata[0] && !rdClr[0] && !wrClr[0]
    && chFlag_q[0] |=> chFlag_q[0])
    else $error("write zero changed flag");
  a_ovf_clr: assert property (@(posedge core_clk) disable iff (!arst_n) // R11
    ovfClr && !(tick && counter_q == tcc_pkg::CNT_MAX) |=> !ovfFlag_q)
    else $error("overflow flag not cleared");
  a_fast_ovf: assert property (@(posedge core_clk) disable iff (!arst_n) // R14
    fastClr && cntAccess && !tick |=> !ovfFlag_q)
    else $error("counter access kept overflow");
  a_fast_rd: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
    rdClr[1] && !capEv[1] |=> !chFlag_q[1])
    else $error("capture read kept flag");
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
    (chFlag_q & irqEn_q) != '0 |=> timerIrq)
    else $error("enabled flag gave no request");
  a_irq_ovf: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
    ovfFlag_q && sysCtrl2_q[tcc_pkg::OVF_IRQ_EN_BIT] |=> timerIrq)
    else $error("overflow gave no request");
  a_irq_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // R6 R7
    (chFlag_q & irqEn_q) == '0 && !(ovfFlag_q && sysCtrl2_q[tcc_pkg::OVF_IRQ_EN_BIT])
    |=> !timerIrq)
    else $error("request without enabled flag");

  // capture on channel 1
  a_cap_copy: assert property (@(posedge core_clk) disable iff (!arst_n) // R19
    capEv[1] |=> chReg_q[1] == $past(counter_q))
    else $error("capture value wrong");
  a_cap_wr_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // R19
    wrPend_q && !modeOut[1] && !capEv[1] |=> $stable(chReg_q[1]))
    else $error("capture register written");
  a_edge_off: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
    edgeLo_q[3:2] == tcc_pkg::EDGE_OFF |-> !capEv[1])
    else $error("capture while disabled");
  a_edge_rise: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
    edgeLo_q[3:2] == tcc_pkg::EDGE_RISE && capEv[1] |-> chanPinIn[1] && !pinPrev_q[1])
    else $error("rising select took other edge");
  a_edge_fall: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
    edgeLo_q[3:2] == tcc_pkg::EDGE_FALL && capEv[1] |-> !chanPinIn[1] && pinPrev_q[1])
    else $error("falling select took other edge");

  // compare on channel 0 and its pin
  a_cmp_hit: assert property (@(posedge core_clk) disable iff (!arst_n) // R21
    cmpEv[0] |-> modeOut[0] && counter_q == chReg_q[0])
    else $error("compare without match");
  a_act_toggle: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
    hit[0] && outLo_q[1:0] == tcc_pkg::ACT_TOGGLE |=> pinOut_q[0] != $past(pinOut_q[0]))
    else $error("toggle action missed");
  a_act_low: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
    hit[0] && outLo_q[1:0] == tcc_pkg::ACT_LOW |=> !pinOut_q[0])
    else $error("low action missed");
  a_act_high: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
    hit[0] && outLo_q[1:0] == tcc_pkg::ACT_HIGH |=> pinOut_q[0])
    else $error("high action missed");
  a_act_none: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
    !hit[0] |=> $stable(pinOut_q[0]))
    else $error("pin line moved without compare");
  a_pin_oe: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
    modeOut[0] && !pinDisc_q[0] |=> chanPinOe[0])
    else $error("compare pin not driven");
  a_pin_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
    chanPinOe[0] |-> !$past(pinDisc_q[0]) && $past(modeOut[0]))
    else $error("pin driven while disconnected");
  a_pin_level: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
    pinDisc_q[0] |=> !chanPinOut[0])
    else $error("disconnected pin shows action");
  a_disc_flag: assert property (@(posedge core_clk) disable iff (!arst_n) // R20
    cmpEv[0] && pinDisc_q[0] |=> chFlag_q[0] && !chanPinOut[0])
    else $error("disconnected compare lost flag");

  // unimplemented bits
  a_rd_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    rdPend_q && idx_q == tcc_pkg::IDX_CH_FLAGS |-> hrdata[31:NCH] == '0)
    else $error("unused flag bits read nonzero");
  a_ovf_rd: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    rdPend_q && idx_q == tcc_pkg::IDX_OVF_FLAGS |-> hrdata[tcc_pkg::OVF_FLAG_BIT-1:0] == '0)
    else $error("unused overflow bits nonzero");
  a_unused_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    outHi_q == tcc_pkg::BYTE_RESET && edgeHi_q == tcc_pkg::BYTE_RESET)
    else $error("unused control bits stored");

  c_capture:  cover property (@(posedge core_clk) capEv[1]);
  c_compare:  cover property (@(posedge core_clk) cmpEv[0] && chanPinOe[0]);
  c_overflow: cover property (@(posedge core_clk) ovfFlag_q && timerIrq);
  c_fast_clr: cover property (@(posedge core_clk) rdClr[1] && chFlag_q[1]);
  c_disc_cmp: cover property (@(posedge core_clk) cmpEv[0] && pinDisc_q[0]);
endmodule : timer_capture_compare_ctrl
`default_nettype wire

// ### logic/tcc_pkg.sv
/*
  constants for the two-channel capture/compare timer control block:
  register offsets, field positions, reset values, prescaler layout.
  assumes a 32-bit AHB-Lite register bus, one register per aligned word.
*/
package tcc_pkg;
  // printed offsets are not all multiples of four: they are indices, byte address is 4x
  localparam logic [5:0] IDX_COUNTER    = 6'h04;
  localparam logic [5:0] IDX_SYS_CTRL1  = 6'h06;
  localparam logic [5:0] IDX_OUT_HI     = 6'h08;
  localparam logic [5:0] IDX_OUT_LO     = 6'h09;
  localparam logic [5:0] IDX_EDGE_HI    = 6'h0a;
  localparam logic [5:0] IDX_EDGE_LO    = 6'h0b;
  localparam logic [5:0] IDX_IRQ_EN     = 6'h0c;
  localparam logic [5:0] IDX_SYS_CTRL2  = 6'h0d;
  localparam logic [5:0] IDX_CH_FLAGS   = 6'h0e;
  localparam logic [5:0] IDX_OVF_FLAGS  = 6'h0f;
  localparam logic [5:0] IDX_CH_REG0    = 6'h10;
  localparam logic [5:0] IDX_CH_REG1    = 6'h11;
  localparam logic [5:0] IDX_PIN_DISC   = 6'h2c;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam int         IDX_LSB        = 2;
  localparam int         IDX_W          = 6;

  // field positions
  localparam int RUN_EN_BIT     = 7;
  localparam int FAST_CLR_BIT   = 4;
  localparam int OVF_IRQ_EN_BIT = 7;
  localparam int OVF_FLAG_BIT   = 7;
  localparam int PRESC_LSB      = 0;
  localparam int PRESC_W        = 3;
  localparam int DIV_W          = 7;    // stages for divide by up to 128

  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  // compare actions and edge selects
  localparam logic [1:0] ACT_NONE   = 2'b00;
  localparam logic [1:0] ACT_TOGGLE = 2'b01;
  localparam logic [1:0] ACT_LOW    = 2'b10;
  localparam logic [1:0] ACT_HIGH   = 2'b11;
  localparam logic [1:0] EDGE_OFF   = 2'b00;
  localparam logic [1:0] EDGE_RISE  = 2'b01;
  localparam logic [1:0] EDGE_FALL  = 2'b10;
  localparam logic [1:0] EDGE_ANY   = 2'b11;
endpackage : tcc_pkg

// ### verif/pin_partner.sv
/*
  model of the outside world on the two channel pins: one external source
  per pin, seen by the timer through a one-cycle input register.
  assumes the bench changes the sources just after core_clk edges.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  // clock
  input  wire logic       core_clk,
  // timer side of the pins
  input  wire logic [1:0] chanPinOut,
  input  wire logic [1:0] chanPinOe,
  // external sources
  input  wire logic [1:0] extDrive,
  output logic      [1:0] chanPinIn
);
  logic [1:0] extQ;

  // the source settles one edge late, so no pulse is shorter than a cycle
  always_ff @(posedge core_clk) begin
    extQ <= extDrive;
  end

  // a driving timer wins the wire; otherwise the source holds it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      chanPinIn[i] = chanPinOe[i] ? chanPinOut[i] : extQ[i];
    end
  end
endmodule : pin_partner
`default_nettype wire

// ### verif/timer_capture_compare_ctrl_test.sv
/*
  self-checking bench for the capture/compare timer control block.
  assumes a zero-wait-state slave; one overflow wait keeps the run long.
*/
`timescale 1ns/100ps
`default_nettype none
module timer_capture_compare_ctrl_test;
  logic        coreClk, arstN, hsel, hwrite, hreadyout, hresp, timerIrq, pinExp;
  logic [1:0]  htrans, pinIn, pinOut, pinOe, extDrive;
  logic [31:0] haddr, hwdata, hrdata, rnd, v, c0, c1;
  logic [15:0] dc;
  logic [1:0]  ec;
  int          n_fail, samples_checked, cycles, t0, tk;
  logic [5:0]  regs [9] = '{tcc_pkg::IDX_OUT_HI, tcc_pkg::IDX_OUT_LO, tcc_pkg::IDX_EDGE_HI,
    tcc_pkg::IDX_EDGE_LO, tcc_pkg::IDX_IRQ_EN, tcc_pkg::IDX_SYS_CTRL2, tcc_pkg::IDX_CH_FLAGS,
    tcc_pkg::IDX_OVF_FLAGS, 6'h01};
  logic [1:0]  acts [5] = '{tcc_pkg::ACT_HIGH, tcc_pkg::ACT_TOGGLE, tcc_pkg::ACT_LOW,
    tcc_pkg::ACT_TOGGLE, tcc_pkg::ACT_HIGH};

  timer_capture_compare_ctrl #(.NCH(2)) DUT (.core_clk(coreClk), .arst_n(arstN), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .chanPinIn(pinIn), .chanPinOut(pinOut), .chanPinOe(pinOe), .timerIrq(timerIrq));
  pin_partner PEER (.core_clk(coreClk), .chanPinOut(pinOut), .chanPinOe(pinOe),
    .extDrive(extDrive), .chanPinIn(pinIn));

  // 25 MHz clock
  initial begin
    coreClk = 1'b0;
    forever #20 coreClk = ~coreClk;
  end

  // hang guard, sized for one full counter wrap plus the short scenarios
  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one single word transfer; read data is taken at the data-phase edge
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge coreClk);
    haddr  <= {24'h0, idx, 2'b00};
    htrans <= tcc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge coreClk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge coreClk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  function automatic logic [31:0] rwMask(input logic [5:0] idx);
    case (idx)
      tcc_pkg::IDX_OUT_LO, tcc_pkg::IDX_EDGE_LO: return 32'h0000000f;
      tcc_pkg::IDX_IRQ_EN:                       return 32'h00000003;
      tcc_pkg::IDX_SYS_CTRL2:                    return 32'h00000087;
      default:                                   return 32'h0;
    endcase
  endfunction : rwMask

  function automatic logic expPin(input logic [1:0] act, input logic prev);
    case (act)
      tcc_pkg::ACT_TOGGLE: return ~prev;
      tcc_pkg::ACT_LOW:    return 1'b0;
      tcc_pkg::ACT_HIGH:   return 1'b1;
      default:             return prev;
    endcase
  endfunction : expPin

  // main sequence
  initial begin
    arstN = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    extDrive = 2'b00;
    rnd = 32'h2e6e719f;
    pinExp = 1'b0;
    repeat (3) @(posedge coreClk);
    arstN <= 1'b1;
    // reset values, random write data, unused bits and unmapped place
    foreach (regs[i]) begin
      rnd = lfsr(rnd);
      xfer(regs[i], 1'b0, 32'h0, v);
      chk("reset value", v, 32'h0);
      xfer(regs[i], 1'b1, rnd, v);
      xfer(regs[i], 1'b0, 32'h0, v);
      chk("readback", v, rnd & rwMask(regs[i]));
      xfer(regs[i], 1'b1, 32'h0, v);
    end
    xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, v);
    chk("stopped counter", v, 32'h0);
    xfer(tcc_pkg::IDX_SYS_CTRL1, 1'b1, 32'h80, v);
    // every prescale code: ticks counted over a measured window
    for (int s = 0; s < 8; s++) begin
      xfer(tcc_pkg::IDX_SYS_CTRL2, 1'b1, 32'(s), v);
      repeat (130) @(posedge coreClk);
      xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, c0);
      t0 = cycles;
      repeat (256) @(posedge coreClk);
      xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, c1);
      tk = (cycles - t0) >> s;
      dc = c1[15:0] - c0[15:0];
      chk("prescale ticks", 32'(dc >= tk && dc <= tk + 1), 32'h1);
    end
    xfer(tcc_pkg::IDX_SYS_CTRL2, 1'b1, 32'h0, v);
    // divide by one only takes over once the divider passes zero
    repeat (130) @(posedge coreClk);
    // compare actions on channel 0; last pass with the pin disconnected
    foreach (acts[i]) begin
      if (i == 4) xfer(tcc_pkg::IDX_PIN_DISC, 1'b1, 32'h1, v);
      xfer(tcc_pkg::IDX_IRQ_EN, 1'b1, {31'h0, i[0]}, v);
      xfer(tcc_pkg::IDX_OUT_LO, 1'b1, {30'h0, acts[i]}, v);
      rnd = lfsr(rnd);
      xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, c0);
      xfer(tcc_pkg::IDX_CH_REG0, 1'b1, c0 + 32'd24 + rnd[3:0], v);
      repeat (48) @(posedge coreClk);
      if (i < 4) pinExp = expPin(acts[i], pinExp);
      if (i < 4) chk("pin level", pinOut[0], pinExp);
      chk("pin enable", pinOe[0], i < 4);
      chk("irq", timerIrq, i[0]);
      xfer(tcc_pkg::IDX_CH_FLAGS, 1'b0, 32'h0, v);
      chk("compare flag", v, 32'h1);
      xfer(tcc_pkg::IDX_CH_FLAGS, 1'b1, 32'h0, v);
      xfer(tcc_pkg::IDX_CH_FLAGS, 1'b1, 32'h1, v);
      xfer(tcc_pkg::IDX_CH_FLAGS, 1'b0, 32'h0, v);
      chk("flag cleared", v, 32'h0);
    end
    xfer(tcc_pkg::IDX_OUT_LO, 1'b1, 32'h0, v);
    xfer(tcc_pkg::IDX_PIN_DISC, 1'b1, 32'h0, v);
    chk("pin released", pinOe[0], 1'b0);
    // capture on channel 1 for every edge code, rising then falling; last pass
    // takes both edges with fast clear on, so the channel read must drop the flag
    for (int e = 0; e < 5; e++) begin
      if (e == 4) xfer(tcc_pkg::IDX_SYS_CTRL1, 1'b1, 32'h90, v);
      ec = (e == 4) ? tcc_pkg::EDGE_ANY : 2'(e);
      xfer(tcc_pkg::IDX_EDGE_LO, 1'b1, {28'h0, ec, 2'b00}, v);
      for (int lv = 1; lv >= 0; lv--) begin
        xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, c0);
        extDrive[1] <= lv[0];
        repeat (6) @(posedge coreClk);
        xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, c1);
        xfer(tcc_pkg::IDX_CH_FLAGS, 1'b0, 32'h0, v);
        chk("capture flag", v, {30'h0, lv ? ec[0] : ec[1], 1'b0});
        xfer(tcc_pkg::IDX_CH_REG1, 1'b0, 32'h0, v);
        dc = v[15:0] - c0[15:0];
        if (e == 3) chk("capture time", 32'(dc <= c1[15:0] - c0[15:0]), 32'h1);
        xfer(tcc_pkg::IDX_CH_FLAGS, 1'b0, 32'h0, v);
        if (e == 4) chk("fast clear", v, 32'h0);
        xfer(tcc_pkg::IDX_CH_FLAGS, 1'b1, 32'h2, v);
      end
    end
    // overflow after one full wrap, its interrupt, then fast clear
    xfer(tcc_pkg::IDX_SYS_CTRL1, 1'b1, 32'h80, v);
    xfer(tcc_pkg::IDX_SYS_CTRL2, 1'b1, 32'h80, v);
    xfer(tcc_pkg::IDX_OVF_FLAGS, 1'b1, 32'h80, v);
    xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, c0);
    repeat (32'h10000 - c0[15:0] + 8) @(posedge coreClk);
    xfer(tcc_pkg::IDX_OVF_FLAGS, 1'b0, 32'h0, v);
    chk("overflow flag", v, 32'h80);
    chk("overflow irq", timerIrq, 1'b1);
    xfer(tcc_pkg::IDX_SYS_CTRL2, 1'b1, 32'h0, v);
    repeat (2) @(posedge coreClk);
    chk("masked irq", timerIrq, 1'b0);
    xfer(tcc_pkg::IDX_OVF_FLAGS, 1'b1, 32'h0, v);
    xfer(tcc_pkg::IDX_OVF_FLAGS, 1'b0, 32'h0, v);
    chk("zero write keeps", v, 32'h80);
    xfer(tcc_pkg::IDX_SYS_CTRL1, 1'b1, 32'h90, v);
    xfer(tcc_pkg::IDX_COUNTER, 1'b0, 32'h0, v);
    xfer(tcc_pkg::IDX_OVF_FLAGS, 1'b0, 32'h0, v);
    chk("counter access clear", v, 32'h0);
    close_out();
  end
endmodule : timer_capture_compare_ctrl_test
`default_nettype wire
